/* File: verilog/drs_pkg.sv */
// package: constants and types of the readback and status block
package drs_pkg;

    // ------------------------------------------------------------
    // frame layout
    // ------------------------------------------------------------
    localparam int FRAME_BITS   = 24;
    localparam int DATA_BITS    = 16;
    localparam int CNT_BITS     = 5;
    localparam int RW_BIT       = 23;
    localparam int ADDR_HI      = 22;
    localparam int ADDR_LO      = 21;
    localparam int SEL_HI       = 20;
    localparam int SEL_LO       = 16;
    localparam int SYNC_STAGES  = 3;
    localparam logic [CNT_BITS-1:0] FRAME_COUNT = 5'h18;
    localparam logic [7:0]          READ_PAD    = 8'h00;

    // ------------------------------------------------------------
    // read select codes
    // ------------------------------------------------------------
    localparam logic [4:0] SEL_DATA_BASE   = 5'h00;
    localparam logic [4:0] SEL_CTRL_BASE   = 5'h04;
    localparam logic [4:0] SEL_GAIN_BASE   = 5'h08;
    localparam logic [4:0] SEL_OFFSET_BASE = 5'h0c;
    localparam logic [4:0] SEL_CLEAR_BASE  = 5'h10;
    localparam logic [4:0] SEL_SLEW_BASE   = 5'h14;
    localparam logic [4:0] SEL_MISC_BASE   = 5'h18;
    localparam logic [1:0] SEL_STATUS      = 2'h0;
    localparam logic [1:0] SEL_MAIN        = 2'h1;
    localparam logic [1:0] SEL_BOOST       = 2'h2;

    // ------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------
    localparam int WR_FUNC_HI = 20;
    localparam int WR_FUNC_LO = 18;
    localparam int CHAN_HI    = 17;
    localparam int CHAN_LO    = 16;
    localparam logic [2:0] WR_FUNC_CHAN_CTRL = 3'h7;
    localparam logic [2:0] WR_FUNC_SOFTWARE  = 3'h4;
    localparam int TOGGLE_BIT_POS = 12;
    localparam int ECHO_BIT_POS   = 11;

    // ------------------------------------------------------------
    // slew word fields
    // ------------------------------------------------------------
    localparam int SLEW_KEY_HI  = 15;
    localparam int SLEW_KEY_LO  = 13;
    localparam logic [2:0] SLEW_KEY = 3'h0;
    localparam int SLEW_EN_BIT  = 12;
    localparam int SLEW_RATE_HI = 6;
    localparam int SLEW_RATE_LO = 3;
    localparam int SLEW_STEP_HI = 2;
    localparam int SLEW_STEP_LO = 0;
    localparam logic [15:0] SLEW_RESET = 16'h0000;

    // ------------------------------------------------------------
    // status word fields
    // ------------------------------------------------------------
    localparam int ST_BOOST_LO = 12;
    localparam int ST_TOGGLE   = 11;
    localparam int ST_PEC      = 10;
    localparam int ST_RAMP     = 9;
    localparam int ST_OTEMP    = 8;
    localparam int ST_VOUT_LO  = 4;
    localparam int ST_IOUT_LO  = 0;
    localparam logic [15:0] STATUS_RESET = 16'h0000;

    typedef enum {LINK_IDLE, LINK_FRAME} drs_link_state_t;

endpackage

/* File: verilog/drs_sync.sv */
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module drs_sync #(
    parameter int                 WIDTH     = 1,
    parameter logic [WIDTH-1:0]   RESET_VAL = '0
) (
    input  wire logic             ref_clk,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] raw_in,
    output logic      [WIDTH-1:0] level_out
);
    import drs_pkg::*;

    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;
    logic [WIDTH-1:0] stage3_reg;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            stage1_reg <= RESET_VAL;
            stage2_reg <= RESET_VAL;
            stage3_reg <= RESET_VAL;
        end else begin
            stage1_reg <= raw_in;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
        end
    end

    // a change counts only once stages two and three agree
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            level_out <= RESET_VAL;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (stage2_reg[i] == stage3_reg[i]) begin
                    level_out[i] <= stage3_reg[i];
                end
            end
        end
    end

endmodule // drs_sync

/* File: verilog/drs_top.sv */
// serial readback, slew setting and status logic of a quad output converter
`timescale 1ns/1ps
module drs_top (
    input  wire logic                   ref_clk,
    input  wire logic                   sys_rst,
    input  wire logic                   sclk,
    input  wire logic                   sync_n,
    input  wire logic                   sdin,
    output logic                        sdo,
    output logic                        sdo_oe_n,
    input  wire logic                   device_addr_bit1,
    input  wire logic                   device_addr_bit0,
    input  wire logic [3:0][15:0]       dac_data_words,
    input  wire logic [3:0][15:0]       dac_ctrl_words,
    input  wire logic [3:0][15:0]       gain_words,
    input  wire logic [3:0][15:0]       offset_words,
    input  wire logic [3:0][15:0]       clear_code_words,
    input  wire logic [15:0]            main_ctrl_word,
    input  wire logic [15:0]            boost_ctrl_word,
    input  wire logic [3:0]             current_mode,
    input  wire logic [3:0]             boost_compliance_lost,
    input  wire logic [3:0]             boost_regulation_fail,
    input  wire logic [3:0]             vout_fault_in,
    input  wire logic [3:0]             iout_fault_in,
    input  wire logic                   over_temp_in,
    input  wire logic [3:0]             channel_stepping,
    input  wire logic                   pec_mismatch,
    output logic      [3:0]             slew_limit_enable,
    output logic      [3:0][3:0]        slew_update_rate,
    output logic      [3:0][2:0]        slew_step_size,
    output logic      [15:0]            status_word,
    output logic                        fault_o,
    output logic                        fault_oe_n
);
    import drs_pkg::*;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] link_lvl;
    logic [1:0] addr_lvl;
    logic       sclk_lvl;
    logic       sync_n_lvl;
    logic       sdin_lvl;
    logic       sclk_prev_reg;
    logic       sync_n_prev_reg;

    drs_sync #(
        .WIDTH     (3),
        .RESET_VAL (3'h6)
    ) u_link_sync (
        .ref_clk   (ref_clk),
        .sys_rst   (sys_rst),
        .raw_in    ({sclk, sync_n, sdin}),
        .level_out (link_lvl)
    );

    // straps filtered like the link pins
    drs_sync #(
        .WIDTH     (2),
        .RESET_VAL (2'h0)
    ) u_addr_sync (
        .ref_clk   (ref_clk),
        .sys_rst   (sys_rst),
        .raw_in    ({device_addr_bit1, device_addr_bit0}),
        .level_out (addr_lvl)
    );

    assign sclk_lvl   = link_lvl[2];
    assign sync_n_lvl = link_lvl[1];
    assign sdin_lvl   = link_lvl[0];

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sclk_prev_reg   <= 1'b1;
            sync_n_prev_reg <= 1'b1;
        end else begin
            sclk_prev_reg   <= sclk_lvl;
            sync_n_prev_reg <= sync_n_lvl;
        end
    end

    logic sclk_fall;
    logic sclk_rise;
    logic frame_start;
    logic frame_stop;

    assign sclk_fall   = sclk_prev_reg & ~sclk_lvl;
    assign sclk_rise   = ~sclk_prev_reg & sclk_lvl;
    assign frame_start = sync_n_prev_reg & ~sync_n_lvl;
    assign frame_stop  = ~sync_n_prev_reg & sync_n_lvl;

    // ------------------------------------------------------------
    // frame tracking
    // ------------------------------------------------------------
    drs_link_state_t         link_state_reg;
    logic [CNT_BITS-1:0]     bit_cnt_reg;
    logic                    frame_done_reg;
    logic [FRAME_BITS-1:0]   rx_shift_reg;

    // exactly 24 bits make a frame
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            link_state_reg <= LINK_IDLE;
            bit_cnt_reg    <= '0;
            frame_done_reg <= 1'b0;
        end else begin
            frame_done_reg <= 1'b0;
            case (link_state_reg)
                LINK_IDLE: begin
                    if (frame_start) begin
                        link_state_reg <= LINK_FRAME;
                        bit_cnt_reg    <= '0;
                    end
                end
                LINK_FRAME: begin
                    if (frame_stop) begin
                        link_state_reg <= LINK_IDLE;
                        frame_done_reg <= (bit_cnt_reg == FRAME_COUNT);
                    end else if (sclk_fall && bit_cnt_reg != '1) begin
                        bit_cnt_reg <= bit_cnt_reg + 5'h01;
                    end
                end
                default: begin
                    link_state_reg <= LINK_IDLE;
                end
            endcase
        end
    end

    // msb first, sampled on falling edge
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_shift_reg <= '0;
        end else if (link_state_reg == LINK_FRAME && sclk_fall) begin
            rx_shift_reg <= {rx_shift_reg[FRAME_BITS-2:0], sdin_lvl};
        end
    end

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    logic       addr_hit;
    logic       is_read;
    logic       is_slew_write;
    logic       is_soft_write;
    logic [1:0] wr_chan;

    // only frames for this device address read or write; the packet error bit takes every frame
    assign addr_hit = (rx_shift_reg[ADDR_HI:ADDR_LO] == addr_lvl);
    assign is_read  = rx_shift_reg[RW_BIT];
    // slew word keyed by zero top bits
    assign is_slew_write = ~is_read
        && rx_shift_reg[WR_FUNC_HI:WR_FUNC_LO] == WR_FUNC_CHAN_CTRL
        && rx_shift_reg[SLEW_KEY_HI:SLEW_KEY_LO] == SLEW_KEY;
    assign is_soft_write = ~is_read && rx_shift_reg[WR_FUNC_HI:WR_FUNC_LO] == WR_FUNC_SOFTWARE;
    assign wr_chan = rx_shift_reg[CHAN_HI:CHAN_LO];

    logic       pend_read_reg;
    logic [4:0] pend_sel_reg;

    // low sixteen bits never reach the read path
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pend_read_reg <= 1'b0;
            pend_sel_reg  <= '0;
        end else if (frame_done_reg) begin
            pend_read_reg <= addr_hit & is_read;
            pend_sel_reg  <= rx_shift_reg[SEL_HI:SEL_LO];
        end
    end

    // ------------------------------------------------------------
    // slew settings and user toggle
    // ------------------------------------------------------------
    logic [3:0][15:0] slew_reg;
    logic             user_toggle_reg;

    // one setting per channel, picked by write
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            slew_reg <= {4{SLEW_RESET}};
        end else if (frame_done_reg && addr_hit && is_slew_write) begin
            // ignored bits are stored as zero
            slew_reg[wr_chan] <= {3'h0, rx_shift_reg[SLEW_EN_BIT], 5'h00,
                                  rx_shift_reg[SLEW_RATE_HI:SLEW_RATE_LO],
                                  rx_shift_reg[SLEW_STEP_HI:SLEW_STEP_LO]};
        end
    end

    always_comb begin
        for (int c = 0; c < 4; c++) begin
            slew_limit_enable[c] = slew_reg[c][SLEW_EN_BIT];
            slew_update_rate[c]  = slew_reg[c][SLEW_RATE_HI:SLEW_RATE_LO];
            slew_step_size[c]    = slew_reg[c][SLEW_STEP_HI:SLEW_STEP_LO];
        end
    end

    // toggle set or cleared by software word
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            user_toggle_reg <= 1'b0;
        end else if (frame_done_reg && addr_hit && is_soft_write) begin
            user_toggle_reg <= rx_shift_reg[TOGGLE_BIT_POS];
        end
    end

    // packet error tracks the latest word only
    logic pec_err_reg;
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pec_err_reg <= 1'b0;
        end else if (frame_done_reg) begin
            pec_err_reg <= pec_mismatch;
        end
    end

    // ------------------------------------------------------------
    // status word
    // ------------------------------------------------------------
    logic [3:0] boost_flag;
    logic [3:0] iout_flag;
    logic       ramp_active;

    assign boost_flag  = (current_mode & boost_compliance_lost) | (~current_mode & boost_regulation_fail);
    assign iout_flag   = iout_fault_in | (current_mode & boost_compliance_lost);
    assign ramp_active = |(channel_stepping & slew_limit_enable);

    // built from state only, no write path
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            status_word <= STATUS_RESET;
        end else begin
            status_word[ST_BOOST_LO+3:ST_BOOST_LO] <= boost_flag;
            status_word[ST_TOGGLE]                 <= user_toggle_reg;
            status_word[ST_PEC]                    <= pec_err_reg;
            status_word[ST_RAMP]                   <= ramp_active;
            status_word[ST_OTEMP]                  <= over_temp_in;
            status_word[ST_VOUT_LO+3:ST_VOUT_LO]   <= vout_fault_in;
            status_word[ST_IOUT_LO+3:ST_IOUT_LO]   <= iout_flag;
        end
    end

    // supply flags left out of the pin
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            fault_o    <= 1'b0;
            fault_oe_n <= 1'b1;
        end else begin
            fault_o    <= 1'b0;
            fault_oe_n <= ~(|status_word[ST_VOUT_LO+3:ST_IOUT_LO] | status_word[ST_PEC]
                            | status_word[ST_OTEMP]);
        end
    end

    // ------------------------------------------------------------
    // readback mux
    // ------------------------------------------------------------
    logic [15:0] read_data;
    logic [1:0]  rsel_ch;

    assign rsel_ch = pend_sel_reg[1:0];

    always_comb begin
        read_data = 16'h0000;
        case (pend_sel_reg[4:2])
            SEL_DATA_BASE[4:2]:   read_data = dac_data_words[rsel_ch];
            SEL_CTRL_BASE[4:2]:   read_data = dac_ctrl_words[rsel_ch];
            SEL_GAIN_BASE[4:2]:   read_data = gain_words[rsel_ch];
            SEL_OFFSET_BASE[4:2]: read_data = offset_words[rsel_ch];
            SEL_CLEAR_BASE[4:2]:  read_data = clear_code_words[rsel_ch];
            SEL_SLEW_BASE[4:2]:   read_data = slew_reg[rsel_ch];
            SEL_MISC_BASE[4:2]: begin
                case (rsel_ch)
                    SEL_STATUS: read_data = status_word;
                    SEL_MAIN:   read_data = main_ctrl_word;
                    SEL_BOOST:  read_data = boost_ctrl_word;
                    default:    read_data = 16'h0000;
                endcase
            end
            default: read_data = 16'h0000;
        endcase
    end

    // ------------------------------------------------------------
    // serial output
    // ------------------------------------------------------------
    logic [FRAME_BITS-1:0] tx_word;
    logic [FRAME_BITS-1:0] tx_shift_reg;

    // a pending read wins over the echo
    always_comb begin
        if (pend_read_reg) begin
            tx_word = {READ_PAD, read_data};
        end else if (main_ctrl_word[ECHO_BIT_POS]) begin
            tx_word = {READ_PAD, status_word};
        end else begin
            tx_word = '0;
        end
    end

    // first bit out at frame start, next on each rising edge
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_shift_reg <= '0;
            sdo          <= 1'b0;
            sdo_oe_n     <= 1'b1;
        end else if (link_state_reg == LINK_IDLE && frame_start) begin
            tx_shift_reg <= tx_word;
            sdo          <= tx_word[FRAME_BITS-1];
            sdo_oe_n     <= 1'b0;
        end else if (link_state_reg == LINK_FRAME && frame_stop) begin
            sdo          <= 1'b0;
            sdo_oe_n     <= 1'b1;
        end else if (link_state_reg == LINK_FRAME && sclk_rise) begin
            tx_shift_reg <= {tx_shift_reg[FRAME_BITS-2:0], 1'b0};
            sdo          <= tx_shift_reg[FRAME_BITS-2];
        end
    end

endmodule // drs_top

/* File: tb/drs_monitor.sv */
// checker on the top ports
`timescale 1ns/1ps
module drs_monitor (
    input wire logic            ref_clk,
    input wire logic            sys_rst,
    input wire logic            sync_n,
    input wire logic            sdo_oe_n,
    input wire logic [3:0]      current_mode,
    input wire logic [3:0]      boost_compliance_lost,
    input wire logic [3:0]      boost_regulation_fail,
    input wire logic [3:0]      vout_fault_in,
    input wire logic [3:0]      iout_fault_in,
    input wire logic            over_temp_in,
    input wire logic [3:0]      channel_stepping,
    input wire logic [3:0]      slew_limit_enable,
    input wire logic [3:0][3:0] slew_update_rate,
    input wire logic [3:0][2:0] slew_step_size,
    input wire logic [15:0]     status_word,
    input wire logic            fault_o,
    input wire logic            fault_oe_n
);
    // ------------------------------------------------------------
    // settle counter
    // ------------------------------------------------------------
    // past values need three edges after reset
    logic [1:0] age_reg;
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst)
            age_reg <= 2'h0;
        else if (age_reg != 2'h3)
            age_reg <= age_reg + 2'h1;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    sequence s_idle;
        sync_n [*8];
    endsequence
    sequence s_open;
        $fell(sync_n) ##1 !sync_n [*7];
    endsequence
    property p_boost_flag;
        age_reg == 2'h3 |-> status_word[15:12] == (($past(current_mode) & $past(boost_compliance_lost))
            | (~$past(current_mode) & $past(boost_regulation_fail)));
    endproperty
    a_boost_flag: assert property (p_boost_flag)
        else $error("supply flags wrong");
    property p_iout;
        age_reg == 2'h3 |-> status_word[3:0] ==
            ($past(iout_fault_in) | ($past(current_mode) & $past(boost_compliance_lost)));
    endproperty
    a_iout: assert property (p_iout)
        else $error("iout bits wrong");
    property p_vout_temp;
        age_reg == 2'h3 |-> status_word[8:4] == {$past(over_temp_in), $past(vout_fault_in)};
    endproperty
    a_vout_temp: assert property (p_vout_temp)
        else $error("vout or temp bit wrong");
    property p_ramp;
        age_reg == 2'h3 |-> status_word[9] == |($past(channel_stepping) & $past(slew_limit_enable));
    endproperty
    a_ramp: assert property (p_ramp)
        else $error("ramp bit wrong");
    property p_fault_pin;
        age_reg == 2'h3 |-> fault_oe_n == !(|($past(status_word) & 16'h05ff));
    endproperty
    a_fault_pin: assert property (p_fault_pin)
        else $error("fault pin wrong");
    property p_fault_level;
        !fault_o;
    endproperty
    a_fault_level: assert property (p_fault_level)
        else $error("fault level high");
    property p_oe_idle;
        s_idle |-> sdo_oe_n;
    endproperty
    a_oe_idle: assert property (p_oe_idle)
        else $error("data out on outside frame");
    property p_oe_open;
        s_open |-> !sdo_oe_n;
    endproperty
    a_oe_open: assert property (p_oe_open)
        else $error("data out idle in frame");
    property p_slew_hold;
        !$stable({slew_limit_enable, slew_update_rate, slew_step_size}) |-> sync_n;
    endproperty
    a_slew_hold: assert property (p_slew_hold)
        else $error("slew changed in frame");
endmodule // drs_monitor

bind drs_top drs_monitor i_mon (.ref_clk, .sys_rst, .sync_n, .sdo_oe_n, .current_mode, .boost_compliance_lost,
    .boost_regulation_fail, .vout_fault_in, .iout_fault_in, .over_temp_in, .channel_stepping, .slew_limit_enable,
    .slew_update_rate, .slew_step_size, .status_word, .fault_o, .fault_oe_n);

/* File: tb/drs_host.sv */
// host model: serial master
`timescale 1ns/1ps
module drs_host (
    input  wire logic  ref_clk,
    input  wire logic  sdo,
    output logic       sclk,
    output logic       sync_n,
    output logic       sdin,
    output logic [23:0] rx_word,
    output logic       rx_done
);
    initial begin
        sclk = 1'b1;
        sync_n = 1'b1;
        sdin = 1'b0;
        rx_word = 24'h000000;
        rx_done = 1'b0;
    end
    // sample late: reply bits trail the rise
    task automatic xfer(input logic [23:0] tx);
        @(negedge ref_clk);
        rx_done = 1'b0;
        sync_n = 1'b0;
        repeat (10) @(negedge ref_clk);
        for (int i = 23; i >= 0; i--) begin
            sdin = tx[i];
            repeat (4) @(negedge ref_clk);
            sclk = 1'b0;
            repeat (4) @(negedge ref_clk);
            rx_word[i] = sdo;
            sclk = 1'b1;
        end
        repeat (4) @(negedge ref_clk);
        sync_n = 1'b1;
        // released line shows no stale bit
        sdin = ~sdin;
        repeat (20) @(negedge ref_clk);
        rx_done = 1'b1;
    endtask
endmodule // drs_host

/* File: tb/tb_drs_top.sv */
// testbench of the readback and status block
`timescale 1ns/1ps
module tb_drs_top;
    import drs_pkg::*;
    localparam logic [23:0] NOOP = 24'h1ce000;
    logic             ref_clk, sys_rst, sclk, sync_n, sdin, sdo, sdo_oe_n, rx_done, fault_o, fault_oe_n;
    logic             device_addr_bit1, device_addr_bit0, over_temp_in, pec_mismatch, exp_tog, exp_pec;
    logic [3:0][15:0] dac_data_words, dac_ctrl_words, gain_words, offset_words, clear_code_words;
    logic [15:0]      main_ctrl_word, boost_ctrl_word, status_word, w;
    logic [3:0]       current_mode, boost_compliance_lost, boost_regulation_fail, vout_fault_in;
    logic [3:0]       iout_fault_in, channel_stepping, slew_limit_enable, exp_en;
    logic [3:0][3:0]  slew_update_rate;
    logic [3:0][2:0]  slew_step_size;
    logic [23:0]      rx_word;
    logic [15:0]      exp_slew [4];
    logic [24:0]      exp_q [$], exp_e;
    logic [31:0]      seed = 32'h44;
    int               failures, check_count, cyc;

    drs_top i_dut (.ref_clk, .sys_rst, .sclk, .sync_n, .sdin, .sdo, .sdo_oe_n, .device_addr_bit1,
        .device_addr_bit0, .dac_data_words, .dac_ctrl_words, .gain_words, .offset_words, .clear_code_words,
        .main_ctrl_word, .boost_ctrl_word, .current_mode, .boost_compliance_lost, .boost_regulation_fail,
        .vout_fault_in, .iout_fault_in, .over_temp_in, .channel_stepping, .pec_mismatch, .slew_limit_enable,
        .slew_update_rate, .slew_step_size, .status_word, .fault_o, .fault_oe_n);
    drs_host i_host (.ref_clk, .sdo, .sclk, .sync_n, .sdin, .rx_word, .rx_done);

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 30000) begin
            failures++;
            summarize();
        end
    end
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [15:0] exp_status();
        logic [3:0] hard;
        hard = current_mode & boost_compliance_lost;
        return {hard | (~current_mode & boost_regulation_fail), exp_tog, exp_pec,
            |(channel_stepping & exp_en), over_temp_in, vout_fault_in, iout_fault_in | hard};
    endfunction
    function automatic logic [15:0] rd_exp(input logic [4:0] s);
        case (s[4:2])
            3'h0: return dac_data_words[s[1:0]];
            3'h1: return dac_ctrl_words[s[1:0]];
            3'h2: return gain_words[s[1:0]];
            3'h3: return offset_words[s[1:0]];
            3'h4: return clear_code_words[s[1:0]];
            3'h5: return exp_slew[s[1:0]];
            3'h6: return s[1] ? (s[0] ? 16'h0000 : boost_ctrl_word) : (s[0] ? main_ctrl_word : exp_status());
            default: return 16'h0000;
        endcase
    endfunction
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic send(input logic [23:0] tx, input logic care, input logic [15:0] ev);
        exp_q.push_back({care, 8'h00, ev});
        i_host.xfer(tx);
    endtask
    task automatic wr(input logic [4:0] fc, input logic [15:0] d);
        send({1'b0, device_addr_bit1, device_addr_bit0, fc, d}, 1'b0, 16'h0000);
    endtask
    // reads pipelined one frame deep
    task automatic sweep(input int lo, input int hi);
        logic [4:0] prev;
        prev = 5'(lo);
        for (int c = lo; c <= hi + 1; c++) begin
            send(c > hi ? NOOP : {1'b1, device_addr_bit1, device_addr_bit0, 5'(c), 16'(rnd())},
                c > lo, rd_exp(prev));
            prev = 5'(c);
        end
    endtask
    task automatic rand_status();
        {current_mode, boost_compliance_lost, boost_regulation_fail, vout_fault_in} = 16'(rnd());
        {iout_fault_in, channel_stepping, over_temp_in} = 9'(rnd());
    endtask
    always @(posedge rx_done) begin
        exp_e = exp_q.pop_front();
        if (exp_e[24])
            check("sdo frame", 32'(rx_word), 32'(exp_e[23:0]));
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        sys_rst = 1'b1;
        {device_addr_bit1, device_addr_bit0} = 2'(rnd());
        for (int i = 0; i < 4; i++) begin
            {dac_data_words[i], dac_ctrl_words[i]} = rnd();
            {gain_words[i], offset_words[i]} = rnd();
            clear_code_words[i] = 16'(rnd());
            exp_slew[i] = 16'h0000;
        end
        main_ctrl_word = 16'(rnd()) & 16'hf7ff;
        boost_ctrl_word = 16'(rnd());
        rand_status();
        {pec_mismatch, exp_en, exp_tog, exp_pec} = 7'h00;
        repeat (10) @(negedge ref_clk);
        check("oe reset", 32'(sdo_oe_n), 32'h1);
        check("slew reset", {slew_limit_enable, slew_update_rate, slew_step_size}, 32'h0);
        sys_rst = 1'b0;
        repeat (10) @(negedge ref_clk);
        sweep(0, 31);
        send({1'b1, ~device_addr_bit1, ~device_addr_bit0, 5'h08, 16'h0000}, 1'b1, 16'h0000);
        send(NOOP, 1'b1, 16'h0000);
        $display("test readback done");
        for (int c = 0; c < 5; c++) begin
            w = c < 4 ? 16'(rnd()) & 16'h1fff : 16'(rnd()) | 16'h8000;
            wr({3'h7, 2'(c)}, w);
            if (c < 4) begin
                exp_slew[c] = {3'h0, w[12], 5'h00, w[6:0]};
                exp_en[c] = w[12];
            end
            for (int j = 0; j < 4; j++)
                check("slew", 32'({slew_limit_enable[j], slew_update_rate[j], slew_step_size[j]}),
                    32'({exp_slew[j][12], exp_slew[j][6:0]}));
        end
        sweep(20, 23);
        $display("test slew done");
        pec_mismatch = 1'b1;
        wr(5'h10, 16'h1000);
        {pec_mismatch, exp_tog, exp_pec} = 3'b011;
        check("toggle pec", 32'(status_word), 32'(exp_status()));
        wr(5'h18, 16'(rnd()));
        exp_pec = 1'b0;
        check("status write", 32'(status_word), 32'(exp_status()));
        wr(5'h10, 16'h0000);
        exp_tog = 1'b0;
        check("toggle clear", 32'(status_word), 32'(exp_status()));
        main_ctrl_word[11] = 1'b1;
        wr(5'h10, 16'h0000);
        send(NOOP, 1'b1, exp_status());
        main_ctrl_word[11] = 1'b0;
        send(NOOP, 1'b1, 16'h0000);
        sweep(24, 24);
        $display("test status and echo done");
        for (int k = 0; k < 40; k++) begin
            rand_status();
            repeat (3) @(negedge ref_clk);
            check("status map", 32'(status_word), 32'(exp_status()));
            check("fault pin", 32'(fault_oe_n), 32'(~|(exp_status() & 16'h05ff)));
        end
        $display("test flags done");
        summarize();
    end
endmodule // tb_drs_top
